// *** shared/param_zero_pkg.sv ***
// Constants, codes and types shared by the command parameter decoder
package param_zero_pkg;
	// ************************************************************
	// Register map and fields
	// ************************************************************
	localparam logic [7:0] OFS_COMMAND = 8'h00;
	localparam logic [7:0] OFS_COPY_MODE = 8'h04;
	localparam logic [7:0] OFS_CONTROL = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0c;
	localparam int CTRL_RESET_BIT = 0;
	localparam int CTRL_MODBUS_BIT = 1;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_TRIP_BIT = 1;
	localparam int STAT_DISP_LSB = 2;
	localparam int STAT_KIND_LSB = 4;
	localparam int STAT_REFUSED_BIT = 9;
	localparam logic [15:0] COMMAND_RESET = 16'h0000;
	localparam logic [2:0] COPY_MODE_RESET = 3'h0;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	// ************************************************************
	// Command parameter values
	// ************************************************************
	localparam logic [15:0] COMMAND_MAX = 16'h7fff;
	localparam logic [15:0] DECIMAL_THOUSAND = 16'h03e8;
	localparam logic [15:0] CODE_NONE = 16'h0000;
	localparam logic [15:0] CODE_SAVE = 16'h0001;
	localparam logic [15:0] CODE_READ_1 = 16'h0002;
	localparam logic [15:0] CODE_STORE_1 = 16'h0003;
	localparam logic [15:0] CODE_READ_2 = 16'h0004;
	localparam logic [15:0] CODE_STORE_2 = 16'h0005;
	localparam logic [15:0] CODE_READ_3 = 16'h0006;
	localparam logic [15:0] CODE_STORE_3 = 16'h0007;
	localparam logic [15:0] CODE_SHOW_CHANGED = 16'h0008;
	localparam logic [15:0] CODE_SHOW_DEST = 16'h0009;
	localparam logic [15:0] CODE_EUR = 16'h000a;
	localparam logic [15:0] CODE_USA = 16'h000b;
	localparam logic [15:0] CODE_OPT_RESET = 16'h000c;
	localparam logic [15:0] CODE_SAVE_ALT = DECIMAL_THOUSAND;
	localparam logic [15:0] CODE_OPT_RESET_ALT = 16'h042e;
	localparam logic [15:0] CODE_EUR_ALT = 16'h04d1;
	localparam logic [15:0] CODE_USA_ALT = 16'h04dc;
	localparam logic [15:0] CODE_EUR_KEEP = 16'h04e7;
	localparam logic [15:0] CODE_USA_KEEP = 16'h04e8;
	localparam logic [15:0] CODE_BOOT_STORE = 16'h07d1;
	localparam logic [15:0] CODE_WARN_CLEAR = 16'h2553;
	localparam logic [15:0] CODE_WARN_SET = 16'h25c2;
	localparam logic [15:0] CODE_RO_CLEAR = 16'h2631;
	localparam logic [15:0] CODE_RO_SET = 16'h26a0;
	localparam logic [15:0] CODE_ERASE_CARD = 16'h270f;
	localparam logic [15:0] CODE_SHOW_CHANGED_NOW = 16'h2ee0;
	localparam logic [15:0] CODE_SHOW_DEST_NOW = 16'h2ee1;
	localparam logic [15:0] DIGIT_STORE_ALL = 16'h0003;
	localparam logic [15:0] DIGIT_STORE_DIFF = 16'h0004;
	localparam logic [15:0] DIGIT_STORE_LADDER = 16'h0005;
	localparam logic [15:0] DIGIT_LOAD = 16'h0006;
	localparam logic [15:0] DIGIT_ERASE = 16'h0007;
	localparam logic [15:0] DIGIT_COMPARE = 16'h0008;
	localparam logic [9:0] BLOCK_ONE = 10'h001;
	localparam logic [9:0] BLOCK_TWO = 10'h002;
	localparam logic [9:0] BLOCK_THREE = 10'h003;
	// ************************************************************
	// Copy mode parameter values
	// ************************************************************
	localparam logic [2:0] COPY_MAX = 3'h4;
	localparam logic [2:0] COPY_CARD_LOW = 3'h3;
	localparam logic [2:0] COPY_CARD_HIGH = 3'h4;
	// ************************************************************
	// Types
	// ************************************************************
	typedef enum logic [4:0] {
		act_none, act_save, act_card_read, act_card_store_diff, act_show_changed,
		act_show_dest, act_def_eur, act_def_usa, act_def_eur_keep, act_def_usa_keep,
		act_option_reset, act_boot_store, act_card_store_all, act_card_store_ladder,
		act_card_erase_block, act_card_compare, act_warn_clear, act_warn_set,
		act_ro_clear, act_ro_set, act_card_erase_all
	} action_type;
	typedef enum logic [1:0] {disp_all, disp_changed, disp_dest} display_type;
	typedef enum logic {st_idle, st_wait} state_type;
endpackage

// *** verilog/param_zero_decoder.sv ***
// Command parameter decoder with AHB-Lite register access
`timescale 1ns/1ps
module param_zero_decoder (
	input wire logic CLK_SYS,
	input wire logic RESET,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	input wire logic DRIVE_RESET,
	input wire logic DRIVE_ENABLED,
	input wire logic ACTION_DONE,
	input wire logic ACTION_FAIL,
	input wire logic ACTION_REFUSED,
	output logic ACTION_REQ,
	output logic [4:0] ACTION_KIND,
	output logic [9:0] ACTION_BLOCK,
	output logic ACTION_CARD_ALSO,
	output logic TRIP,
	output logic [1:0] DISPLAY_MODE,
	output logic BUSY
);
	// ************************************************************
	// Decoding functions
	// ************************************************************
	function automatic param_zero_pkg::action_type decode_kind(input logic [15:0] v);
		logic [15:0] digit;
		param_zero_pkg::action_type k;
		digit = v / param_zero_pkg::DECIMAL_THOUSAND;
		k = param_zero_pkg::act_none;
		case (v)
			param_zero_pkg::CODE_SAVE, param_zero_pkg::CODE_SAVE_ALT: k = param_zero_pkg::act_save;
			param_zero_pkg::CODE_READ_1, param_zero_pkg::CODE_READ_2,
			param_zero_pkg::CODE_READ_3: k = param_zero_pkg::act_card_read;
			param_zero_pkg::CODE_STORE_1, param_zero_pkg::CODE_STORE_2,
			param_zero_pkg::CODE_STORE_3: k = param_zero_pkg::act_card_store_diff;
			param_zero_pkg::CODE_SHOW_CHANGED: k = param_zero_pkg::act_show_changed;
			param_zero_pkg::CODE_SHOW_DEST: k = param_zero_pkg::act_show_dest;
			param_zero_pkg::CODE_EUR, param_zero_pkg::CODE_EUR_ALT: k = param_zero_pkg::act_def_eur;
			param_zero_pkg::CODE_USA, param_zero_pkg::CODE_USA_ALT: k = param_zero_pkg::act_def_usa;
			param_zero_pkg::CODE_EUR_KEEP: k = param_zero_pkg::act_def_eur_keep;
			param_zero_pkg::CODE_USA_KEEP: k = param_zero_pkg::act_def_usa_keep;
			param_zero_pkg::CODE_OPT_RESET,
			param_zero_pkg::CODE_OPT_RESET_ALT: k = param_zero_pkg::act_option_reset;
			param_zero_pkg::CODE_BOOT_STORE: k = param_zero_pkg::act_boot_store;
			param_zero_pkg::CODE_WARN_CLEAR: k = param_zero_pkg::act_warn_clear;
			param_zero_pkg::CODE_WARN_SET: k = param_zero_pkg::act_warn_set;
			param_zero_pkg::CODE_RO_CLEAR: k = param_zero_pkg::act_ro_clear;
			param_zero_pkg::CODE_RO_SET: k = param_zero_pkg::act_ro_set;
			param_zero_pkg::CODE_ERASE_CARD: k = param_zero_pkg::act_card_erase_all;
			default: begin
				// Display codes 12000/12001 fall here on purpose: they never wait for a reset
				case (digit)
					param_zero_pkg::DIGIT_STORE_ALL: k = param_zero_pkg::act_card_store_all;
					param_zero_pkg::DIGIT_STORE_DIFF: k = param_zero_pkg::act_card_store_diff;
					param_zero_pkg::DIGIT_STORE_LADDER: k = param_zero_pkg::act_card_store_ladder;
					param_zero_pkg::DIGIT_LOAD: k = param_zero_pkg::act_card_read;
					param_zero_pkg::DIGIT_ERASE: k = param_zero_pkg::act_card_erase_block;
					param_zero_pkg::DIGIT_COMPARE: k = param_zero_pkg::act_card_compare;
					default: k = param_zero_pkg::act_none;
				endcase
			end
		endcase
		return k;
	endfunction

	function automatic logic [9:0] decode_block(input logic [15:0] v);
		logic [15:0] rest;
		logic [9:0] b;
		rest = v % param_zero_pkg::DECIMAL_THOUSAND;
		case (v)
			param_zero_pkg::CODE_READ_1, param_zero_pkg::CODE_STORE_1,
			param_zero_pkg::CODE_BOOT_STORE: b = param_zero_pkg::BLOCK_ONE;
			param_zero_pkg::CODE_READ_2, param_zero_pkg::CODE_STORE_2: b = param_zero_pkg::BLOCK_TWO;
			param_zero_pkg::CODE_READ_3, param_zero_pkg::CODE_STORE_3: b = param_zero_pkg::BLOCK_THREE;
			default: b = rest[9:0];
		endcase
		return b;
	endfunction

	function automatic logic is_default_load(input param_zero_pkg::action_type k);
		return (k == param_zero_pkg::act_def_eur) || (k == param_zero_pkg::act_def_usa) ||
			(k == param_zero_pkg::act_def_eur_keep) || (k == param_zero_pkg::act_def_usa_keep);
	endfunction

	function automatic logic [2:0] copy_after_success(input logic [2:0] c);
		return (c < param_zero_pkg::COPY_CARD_LOW) ? param_zero_pkg::COPY_MODE_RESET : c;
	endfunction

	// ************************************************************
	// Bus address phase
	// ************************************************************
	logic wr_en_ff, nxt_wr_en_ff;
	logic [7:0] wr_ofs_ff, nxt_wr_ofs_ff;
	logic [31:0] rdata_ff, nxt_rdata_ff;
	logic addr_take;
	logic addr_mapped;

	logic [15:0] command_ff, nxt_command_ff;
	logic [2:0] copy_mode_ff, nxt_copy_mode_ff;
	logic modbus_ff, nxt_modbus_ff;
	param_zero_pkg::state_type state_ff, nxt_state_ff;
	param_zero_pkg::action_type kind_ff, nxt_kind_ff;
	param_zero_pkg::display_type display_ff, nxt_display_ff;
	logic [9:0] block_ff, nxt_block_ff;
	logic card_also_ff, nxt_card_also_ff;
	logic req_ff, nxt_req_ff;
	logic trip_ff, nxt_trip_ff;
	logic trip_seen_ff, nxt_trip_seen_ff;
	logic refused_ff, nxt_refused_ff;

	always_comb begin
		addr_take = HSEL && HREADY && (HTRANS == param_zero_pkg::HTRANS_NONSEQ);
		addr_mapped = (HADDR[31:8] == 24'h000000) && (HADDR[1:0] == 2'h0);
		nxt_wr_en_ff = addr_take && HWRITE && addr_mapped && (HSIZE == param_zero_pkg::HSIZE_WORD);
		nxt_wr_ofs_ff = addr_take ? HADDR[7:0] : wr_ofs_ff;
		nxt_rdata_ff = 32'h00000000;
		// Read data is sampled during the address phase so the slave never stalls
		if (addr_take && !HWRITE && addr_mapped) begin
			case (HADDR[7:0])
				param_zero_pkg::OFS_COMMAND: nxt_rdata_ff[15:0] = command_ff;
				param_zero_pkg::OFS_COPY_MODE: nxt_rdata_ff[2:0] = copy_mode_ff;
				param_zero_pkg::OFS_CONTROL: nxt_rdata_ff[param_zero_pkg::CTRL_MODBUS_BIT] = modbus_ff;
				param_zero_pkg::OFS_STATUS: begin
					nxt_rdata_ff[param_zero_pkg::STAT_BUSY_BIT] = (state_ff == param_zero_pkg::st_wait);
					nxt_rdata_ff[param_zero_pkg::STAT_TRIP_BIT] = trip_seen_ff;
					nxt_rdata_ff[param_zero_pkg::STAT_DISP_LSB +: 2] = display_ff;
					nxt_rdata_ff[param_zero_pkg::STAT_KIND_LSB +: 5] = kind_ff;
					nxt_rdata_ff[param_zero_pkg::STAT_REFUSED_BIT] = refused_ff;
				end
				default: nxt_rdata_ff = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge CLK_SYS or posedge RESET) begin
		if (RESET) begin
			wr_en_ff <= 1'b0;
			wr_ofs_ff <= 8'h00;
			rdata_ff <= 32'h00000000;
		end else begin
			wr_en_ff <= nxt_wr_en_ff;
			wr_ofs_ff <= nxt_wr_ofs_ff;
			rdata_ff <= nxt_rdata_ff;
		end
	end

	// ************************************************************
	// Command core
	// ************************************************************
	logic drive_reset_now;
	param_zero_pkg::action_type start_kind;

	always_comb begin
		nxt_command_ff = command_ff;
		nxt_copy_mode_ff = copy_mode_ff;
		nxt_modbus_ff = modbus_ff;
		nxt_state_ff = state_ff;
		nxt_kind_ff = kind_ff;
		nxt_display_ff = display_ff;
		nxt_block_ff = block_ff;
		nxt_card_also_ff = card_also_ff;
		nxt_req_ff = 1'b0;
		nxt_trip_ff = 1'b0;
		nxt_trip_seen_ff = trip_seen_ff;
		nxt_refused_ff = refused_ff;
		drive_reset_now = DRIVE_RESET;
		start_kind = decode_kind(command_ff);

		// Software writes; parameters are frozen while an action runs
		if (wr_en_ff) begin
			case (wr_ofs_ff)
				param_zero_pkg::OFS_COMMAND: begin
					if (state_ff == param_zero_pkg::st_idle && HWDATA[31:16] == 16'h0000 &&
						HWDATA[15:0] <= param_zero_pkg::COMMAND_MAX) begin
						nxt_command_ff = HWDATA[15:0];
						if (modbus_ff && HWDATA[15:0] == param_zero_pkg::CODE_SHOW_CHANGED_NOW) begin
							nxt_display_ff = param_zero_pkg::disp_changed;
						end
						if (modbus_ff && HWDATA[15:0] == param_zero_pkg::CODE_SHOW_DEST_NOW) begin
							nxt_display_ff = param_zero_pkg::disp_dest;
						end
					end
				end
				param_zero_pkg::OFS_COPY_MODE: begin
					if (state_ff == param_zero_pkg::st_idle && HWDATA[31:3] == 29'h00000000 &&
						HWDATA[2:0] <= param_zero_pkg::COPY_MAX) begin
						nxt_copy_mode_ff = HWDATA[2:0];
					end
				end
				param_zero_pkg::OFS_CONTROL: begin
					nxt_modbus_ff = HWDATA[param_zero_pkg::CTRL_MODBUS_BIT];
					drive_reset_now = DRIVE_RESET || HWDATA[param_zero_pkg::CTRL_RESET_BIT];
				end
				param_zero_pkg::OFS_STATUS: begin
					if (HWDATA[param_zero_pkg::STAT_TRIP_BIT]) begin
						nxt_trip_seen_ff = 1'b0;
					end
				end
				default: nxt_command_ff = command_ff;
			endcase
		end

		case (state_ff)
			param_zero_pkg::st_idle: begin
				// A reset acts on the value held before this cycle's write
				if (drive_reset_now) begin
					nxt_refused_ff = 1'b0;
					case (start_kind)
						// Leave the command alone so a write landing in this cycle is kept
						param_zero_pkg::act_none: nxt_refused_ff = 1'b0;
						param_zero_pkg::act_show_changed, param_zero_pkg::act_show_dest: begin
							nxt_display_ff = (start_kind == param_zero_pkg::act_show_changed) ?
								param_zero_pkg::disp_changed : param_zero_pkg::disp_dest;
							nxt_command_ff = param_zero_pkg::COMMAND_RESET;
							nxt_copy_mode_ff = copy_after_success(copy_mode_ff);
						end
						default: begin
							if (is_default_load(start_kind) && DRIVE_ENABLED) begin
								nxt_refused_ff = 1'b1;
							end else begin
								nxt_kind_ff = start_kind;
								nxt_block_ff = decode_block(command_ff);
								nxt_card_also_ff = (start_kind == param_zero_pkg::act_save) &&
									((copy_mode_ff == param_zero_pkg::COPY_CARD_LOW) ||
									(copy_mode_ff == param_zero_pkg::COPY_CARD_HIGH));
								nxt_req_ff = 1'b1;
								nxt_state_ff = param_zero_pkg::st_wait;
							end
						end
					endcase
				end
			end
			param_zero_pkg::st_wait: begin
				if (ACTION_DONE) begin
					nxt_command_ff = param_zero_pkg::COMMAND_RESET;
					nxt_copy_mode_ff = copy_after_success(copy_mode_ff);
					if (kind_ff == param_zero_pkg::act_boot_store) begin
						nxt_copy_mode_ff = param_zero_pkg::COPY_MODE_RESET;
					end
					nxt_state_ff = param_zero_pkg::st_idle;
				end else if (ACTION_FAIL) begin
					// Trip set wins over a clear written in the same cycle
					nxt_trip_ff = 1'b1;
					nxt_trip_seen_ff = 1'b1;
					nxt_state_ff = param_zero_pkg::st_idle;
				end else if (ACTION_REFUSED) begin
					nxt_refused_ff = 1'b1;
					nxt_state_ff = param_zero_pkg::st_idle;
				end
			end
			default: nxt_state_ff = param_zero_pkg::st_idle;
		endcase
	end

	always_ff @(posedge CLK_SYS or posedge RESET) begin
		if (RESET) begin
			command_ff <= param_zero_pkg::COMMAND_RESET;
			copy_mode_ff <= param_zero_pkg::COPY_MODE_RESET;
			modbus_ff <= 1'b0;
			state_ff <= param_zero_pkg::st_idle;
			kind_ff <= param_zero_pkg::act_none;
			display_ff <= param_zero_pkg::disp_all;
			block_ff <= 10'h000;
			card_also_ff <= 1'b0;
			req_ff <= 1'b0;
			trip_ff <= 1'b0;
			trip_seen_ff <= 1'b0;
			refused_ff <= 1'b0;
		end else begin
			command_ff <= nxt_command_ff;
			copy_mode_ff <= nxt_copy_mode_ff;
			modbus_ff <= nxt_modbus_ff;
			state_ff <= nxt_state_ff;
			kind_ff <= nxt_kind_ff;
			display_ff <= nxt_display_ff;
			block_ff <= nxt_block_ff;
			card_also_ff <= nxt_card_also_ff;
			req_ff <= nxt_req_ff;
			trip_ff <= nxt_trip_ff;
			trip_seen_ff <= nxt_trip_seen_ff;
			refused_ff <= nxt_refused_ff;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	always_comb begin
		HRDATA = rdata_ff;
		HREADYOUT = 1'b1;
		HRESP = 1'b0;
		ACTION_REQ = req_ff;
		ACTION_KIND = kind_ff;
		ACTION_BLOCK = block_ff;
		ACTION_CARD_ALSO = card_also_ff;
		TRIP = trip_ff;
		DISPLAY_MODE = display_ff;
		BUSY = (state_ff == param_zero_pkg::st_wait);
	end
endmodule // param_zero_decoder

// *** sim/param_zero_properties.sv ***
// Concurrent checks on the command parameter decoder ports
`timescale 1ns/1ps
module param_zero_checker (
	input wire logic CLK_SYS,
	input wire logic RESET,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	input wire logic DRIVE_RESET,
	input wire logic ACTION_DONE,
	input wire logic ACTION_FAIL,
	input wire logic ACTION_REFUSED,
	input wire logic ACTION_REQ,
	input wire logic [9:0] ACTION_BLOCK,
	input wire logic ACTION_CARD_ALSO,
	input wire logic TRIP,
	input wire logic [1:0] DISPLAY_MODE,
	input wire logic BUSY
);
	// ************************************************************
	// Helper logic
	// ************************************************************
	logic wr_ctl_ff;
	logic nxt_wr_ctl;
	logic rst_evt;
	always_comb begin
		nxt_wr_ctl = HSEL && HREADY && HTRANS == param_zero_pkg::HTRANS_NONSEQ && HWRITE
			&& HSIZE == param_zero_pkg::HSIZE_WORD && HADDR == {24'h0, param_zero_pkg::OFS_CONTROL};
	end
	always_ff @(posedge CLK_SYS or posedge RESET) begin
		if (RESET) begin
			wr_ctl_ff <= 1'b0;
		end else begin
			wr_ctl_ff <= nxt_wr_ctl;
		end
	end
	// Zero wait slave, so the data phase is always the cycle after the address phase
	assign rst_evt = DRIVE_RESET || (wr_ctl_ff && HWDATA[param_zero_pkg::CTRL_RESET_BIT]);
	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (RESET);
	chk_req_pulse: assert property (ACTION_REQ |=> !ACTION_REQ)
		else $error("start request longer than one cycle");
	chk_req_busy: assert property (ACTION_REQ |-> BUSY)
		else $error("start request without busy");
	chk_req_cause: assert property (ACTION_REQ |-> $past(rst_evt))
		else $error("start request without a drive reset");
	chk_busy_no_req: assert property (BUSY |=> !ACTION_REQ)
		else $error("new start while still busy");
	chk_trip_fail: assert property (BUSY && ACTION_FAIL && !ACTION_DONE |=> TRIP)
		else $error("failure did not trip");
	chk_trip_cause: assert property (TRIP |-> $past(BUSY && ACTION_FAIL))
		else $error("trip without failure");
	chk_busy_end: assert property (BUSY && (ACTION_DONE || ACTION_FAIL || ACTION_REFUSED)
		|=> !BUSY)
		else $error("busy kept after answer");
	chk_block_held: assert property ($changed(ACTION_BLOCK) |-> ACTION_REQ)
		else $error("block number changed without a start");
	cov_start: cover property (ACTION_REQ);
	cov_trip: cover property (TRIP);
	cov_card_also: cover property (ACTION_REQ && ACTION_CARD_ALSO);
	cov_dest: cover property (DISPLAY_MODE == 2'h2);
endmodule // param_zero_checker

bind param_zero_decoder param_zero_checker chk (.CLK_SYS(CLK_SYS), .RESET(RESET), .HSEL(HSEL),
	.HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
	.HREADY(HREADY), .DRIVE_RESET(DRIVE_RESET), .ACTION_DONE(ACTION_DONE),
	.ACTION_FAIL(ACTION_FAIL), .ACTION_REFUSED(ACTION_REFUSED), .ACTION_REQ(ACTION_REQ),
	.ACTION_BLOCK(ACTION_BLOCK), .ACTION_CARD_ALSO(ACTION_CARD_ALSO), .TRIP(TRIP),
	.DISPLAY_MODE(DISPLAY_MODE), .BUSY(BUSY));

// *** sim/card_partner.sv ***
// Behavioural model of the removable card answering action requests
`timescale 1ns/1ps
module card_partner (
	input wire logic clk,
	input wire logic rst,
	input wire logic req,
	input wire logic fail_mode,
	input wire logic refuse_mode,
	input wire logic [3:0] delay,
	output logic done,
	output logic fail,
	output logic refused
);
	logic pend_ff;
	logic [3:0] cnt_ff;
	// ************************************************************
	// Answer after a programmable wait, success, failure or refusal
	// ************************************************************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pend_ff <= 1'b0;
			cnt_ff <= 4'h0;
			done <= 1'b0;
			fail <= 1'b0;
			refused <= 1'b0;
		end else begin
			done <= 1'b0;
			fail <= 1'b0;
			refused <= 1'b0;
			if (req) begin
				pend_ff <= 1'b1;
				cnt_ff <= delay;
			end else if (pend_ff && cnt_ff == 4'h0) begin
				pend_ff <= 1'b0;
				done <= !fail_mode && !refuse_mode;
				fail <= fail_mode && !refuse_mode;
				refused <= refuse_mode;
			end else if (pend_ff) begin
				cnt_ff <= cnt_ff - 4'h1;
			end
		end
	end
endmodule // card_partner

// *** sim/param_zero_decoder_bench.sv ***
// Self-checking bench for the command parameter decoder
`timescale 1ns/1ps
module param_zero_decoder_bench;
	localparam logic [7:0] a_cmd = param_zero_pkg::OFS_COMMAND;
	localparam logic [7:0] a_cpy = param_zero_pkg::OFS_COPY_MODE;
	localparam logic [7:0] a_ctl = param_zero_pkg::OFS_CONTROL;
	localparam logic [7:0] a_st = param_zero_pkg::OFS_STATUS;
	logic clk, rst, hsel, hwrite, drv_rst, drv_en, fail_mode, hreadyout, hresp;
	logic done, fail, refused, req, card_also, trip, busy, refuse_mode;
	logic [1:0] htrans, disp;
	logic [2:0] hsize;
	logic [3:0] delay;
	logic [4:0] kind;
	logic [9:0] blk;
	logic [31:0] haddr, hwdata, hrdata, rd;
	int fails, num_checks, cyc, i;
	logic [15:0] codes [28] = '{16'h0001, 16'h03e8, 16'h0002, 16'h0003, 16'h0004, 16'h0005,
		16'h0006, 16'h0007, 16'h000a, 16'h04d1, 16'h000b, 16'h04dc, 16'h04e7, 16'h04e8, 16'h000c,
		16'h042e, 16'h07d1, 16'h0bbd, 16'h0faa, 16'h139c, 16'h1b57, 16'h1b5b, 16'h1f44, 16'h2553,
		16'h25c2, 16'h2631, 16'h26a0, 16'h270f};
	logic [4:0] kinds [28] = '{5'h01, 5'h01, 5'h02, 5'h03, 5'h02, 5'h03, 5'h02, 5'h03, 5'h06,
		5'h06, 5'h07, 5'h07, 5'h08, 5'h09, 5'h0a, 5'h0a, 5'h0b, 5'h0c, 5'h03, 5'h0d, 5'h02, 5'h0e,
		5'h0f, 5'h10, 5'h11, 5'h12, 5'h13, 5'h14};
	// A block of 3ff marks codes without a block number
	logic [9:0] blks [28] = '{10'h3ff, 10'h3ff, 10'h001, 10'h001, 10'h002, 10'h002, 10'h003,
		10'h003, 10'h3ff, 10'h3ff, 10'h3ff, 10'h3ff, 10'h3ff, 10'h3ff, 10'h3ff, 10'h3ff, 10'h001,
		10'h005, 10'h00a, 10'h014, 10'h3e7, 10'h003, 10'h004, 10'h3ff, 10'h3ff, 10'h3ff, 10'h3ff,
		10'h3ff};
	param_zero_decoder uut (.CLK_SYS(clk), .RESET(rst), .HSEL(hsel), .HADDR(haddr),
		.HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout),
		.HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .DRIVE_RESET(drv_rst),
		.DRIVE_ENABLED(drv_en), .ACTION_DONE(done), .ACTION_FAIL(fail),
		.ACTION_REFUSED(refused), .ACTION_REQ(req), .ACTION_KIND(kind), .ACTION_BLOCK(blk),
		.ACTION_CARD_ALSO(card_also), .TRIP(trip), .DISPLAY_MODE(disp), .BUSY(busy));
	card_partner card (.clk(clk), .rst(rst), .req(req), .fail_mode(fail_mode),
		.refuse_mode(refuse_mode), .delay(delay), .done(done), .fail(fail), .refused(refused));
	// ************************************************************
	// Clock, timeout and tasks
	// ************************************************************
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			give_verdict();
		end
	end
	task give_verdict;
		if (fails == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= param_zero_pkg::HTRANS_NONSEQ;
		hwrite <= wr;
		haddr <= {24'h0, a};
		hsize <= param_zero_pkg::HSIZE_WORD;
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task rdchk(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		check(rd, e);
		check(32'(hresp), 32'h0);
	endtask
	// Set copy mode and command, fire a drive reset, follow the action to its end
	task run(input logic [15:0] code, input logic [2:0] cp, input logic f, input logic p,
		input logic r, input logic [4:0] k, input logic [9:0] b, input logic [15:0] ec,
		input logic [2:0] ecp);
		int n;
		bus(1'b1, a_cpy, 32'(cp));
		bus(1'b1, a_cmd, 32'(code));
		fail_mode <= f;
		delay <= code[3:0];
		check(32'(busy), 32'h0);
		if (p) begin
			drv_rst <= 1'b1;
			@(posedge clk);
			drv_rst <= 1'b0;
		end else begin
			bus(1'b1, a_ctl, 32'h1);
		end
		@(posedge clk);
		check(32'(req), 32'(r));
		if (r) check(32'(kind), 32'(k));
		if (r && b != 10'h3ff) check(32'(blk), 32'(b));
		n = 0;
		while (busy !== 1'b0 && n < 100) begin
			@(posedge clk);
			n++;
		end
		bus(1'b0, a_st, 32'h0);
		check(32'(rd[1]), 32'(f & r));
		if (rd[1]) bus(1'b1, a_st, 32'h2);
		rdchk(a_cmd, 32'(ec));
		rdchk(a_cpy, 32'(ecp));
	endtask
	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		rst = 1'b1;
		{hsel, hwrite, drv_rst, drv_en, fail_mode, refuse_mode} = 6'h00;
		htrans = 2'h0;
		hsize = 3'h0;
		delay = 4'h0;
		haddr = 32'h0;
		hwdata = 32'h0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rdchk(a_cmd, 32'h0);
		rdchk(a_cpy, 32'h0);
		rdchk(8'h40, 32'h0);
		bus(1'b1, a_cmd, 32'h8000);
		rdchk(a_cmd, 32'h0);
		bus(1'b1, a_cmd, 32'h7fff);
		rdchk(a_cmd, 32'h7fff);
		for (i = 0; i < 28; i++) run(codes[i], 3'h0, 1'b0, i[0], 1'b1, kinds[i], blks[i], 16'h0, 3'h0);
		run(16'h0000, 3'h0, 1'b0, 1'b0, 1'b0, 5'h0, 10'h3ff, 16'h0, 3'h0);
		run(16'h2328, 3'h0, 1'b0, 1'b1, 1'b0, 5'h0, 10'h3ff, 16'h2328, 3'h0);
		run(16'h0003, 3'h0, 1'b1, 1'b0, 1'b1, 5'h03, 10'h001, 16'h0003, 3'h0);
		run(16'h0003, 3'h2, 1'b0, 1'b0, 1'b1, 5'h03, 10'h001, 16'h0, 3'h0);
		run(16'h0001, 3'h3, 1'b0, 1'b1, 1'b1, 5'h01, 10'h3ff, 16'h0, 3'h3);
		check(32'(card_also), 32'h1);
		run(16'h07d1, 3'h4, 1'b0, 1'b0, 1'b1, 5'h0b, 10'h001, 16'h0, 3'h0);
		drv_en <= 1'b1;
		run(16'h000a, 3'h0, 1'b0, 1'b0, 1'b0, 5'h0, 10'h3ff, 16'h000a, 3'h0);
		bus(1'b0, a_st, 32'h0);
		check(32'(rd[9]), 32'h1);
		drv_en <= 1'b0;
		// A card that refuses after the start keeps the command and raises no trip
		refuse_mode <= 1'b1;
		run(16'h0005, 3'h0, 1'b0, 1'b0, 1'b1, 5'h03, 10'h002, 16'h0005, 3'h0);
		bus(1'b0, a_st, 32'h0);
		check(32'(rd[9]), 32'h1);
		refuse_mode <= 1'b0;
		run(16'h0008, 3'h0, 1'b0, 1'b0, 1'b0, 5'h0, 10'h3ff, 16'h0, 3'h0);
		check(32'(disp), 32'h1);
		run(16'h0009, 3'h0, 1'b0, 1'b1, 1'b0, 5'h0, 10'h3ff, 16'h0, 3'h0);
		check(32'(disp), 32'h2);
		// Outside Modbus mode the immediate display codes must not act
		bus(1'b1, a_cmd, 32'h2ee0);
		repeat (2) @(posedge clk);
		check(32'(disp), 32'h2);
		bus(1'b1, a_ctl, 32'h2);
		bus(1'b1, a_cmd, 32'h2ee0);
		repeat (2) @(posedge clk);
		check(32'(disp), 32'h1);
		bus(1'b1, a_cmd, 32'h2ee1);
		repeat (2) @(posedge clk);
		check(32'(disp), 32'h2);
		give_verdict();
	end
endmodule // param_zero_decoder_bench
